/* common/hrpc_consts.vh */
// How it works
// RL1 - Upper pointer bit 7 chooses read or write
// RL2 - Upper pointer bit 6 enables step after access
// RL3 - Eleven-bit RAM address from both pointer bytes
// RL4 - Reserved pointer and select bits read zero
// RL5 - Three-bit select picks indirect register at 07
// RL6 - Low select bits shared with configuration
// RL7 - Configuration write clears top select bit
// RL8 - Configuration bit 7 holds software reset
// RL9 - Software reset touches only status registers
// RL10 - Configuration bit 6 enables command chaining
// RL11 - Bit 5 low keeps line outputs inactive
// RL12 - Host sets transmit enable after node id
// RL13 - Bits 4,3 scale response and idle timeouts
// RL14 - Reconfiguration time 13.44 or 6.72 ms
// RL15 - All nodes use identical timeout settings
// RL16 - Bit 2 selects backplane signalling, write one
// RL17 - Step carries into upper bits and wraps
// RL18 - Hardware reset clears pointer, select, transmit
/*
 * Constants of the host RAM pointer and configuration register bank.
 * Assumes inclusion by bare name from the design file only.
 */
`ifndef HRPC_CONSTS_VH
`define HRPC_CONSTS_VH

// Word indices on the Avalon bus; byte address is four times this.
`define HRPC_IDX_PTR_UPPER 3'h2
`define HRPC_IDX_PTR_LOWER 3'h3
`define HRPC_IDX_CONFIG 3'h6
`define HRPC_IDX_INDIRECT 3'h7
`define HRPC_IDX_SELECT 3'h4

// Field positions.
`define HRPC_BIT_DIR 7
`define HRPC_BIT_STEP 6
`define HRPC_BIT_SWRST 7
`define HRPC_BIT_CHAIN 6
`define HRPC_BIT_TXON 5
`define HRPC_BIT_BACKPLANE 2

// Indirect select codes.
`define HRPC_SEL_TENTATIVE 3'h0
`define HRPC_SEL_NODE 3'h1
`define HRPC_SEL_SETUP1 3'h2
`define HRPC_SEL_NEXT 3'h3
`define HRPC_SEL_SETUP2 3'h4

// Reset values.
`define HRPC_CONFIG_RESET 8'h00
`define HRPC_BYTE_RESET 8'h00

// Timeouts in nanoseconds, index by timeout_scale.
`define HRPC_RESP_NS_0 9548000
`define HRPC_RESP_NS_1 4774000
`define HRPC_RESP_NS_2 2387000
`define HRPC_RESP_NS_3 597000
`define HRPC_IDLE_NS_0 10496000
`define HRPC_IDLE_NS_1 5248000
`define HRPC_IDLE_NS_2 2624000
`define HRPC_IDLE_NS_3 656000
`define HRPC_RECON_NS_LONG 13440000
`define HRPC_RECON_NS_SHORT 6720000
`define HRPC_CLK_NS 4

`endif

/* src/hrpc_reg_bank.v */
/*
 * Register bank for RAM pointer, indirect select and configuration.
 * Assumes an Avalon-MM master on one 250 MHz clock, a RAM port and an
 * indirect register file outside, and a protocol engine that consumes
 * the timeout counts and line enables driven here.
 */
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hrpc_consts.vh"

module hrpc_reg_bank #(
    parameter ADDR_W = 11,
    parameter [31:0] RESP_CYC_0 = `HRPC_RESP_NS_0 / `HRPC_CLK_NS,
    parameter [31:0] RESP_CYC_1 = `HRPC_RESP_NS_1 / `HRPC_CLK_NS,
    parameter [31:0] RESP_CYC_2 = `HRPC_RESP_NS_2 / `HRPC_CLK_NS,
    parameter [31:0] RESP_CYC_3 = `HRPC_RESP_NS_3 / `HRPC_CLK_NS,
    parameter [31:0] IDLE_CYC_0 = `HRPC_IDLE_NS_0 / `HRPC_CLK_NS,
    parameter [31:0] IDLE_CYC_1 = `HRPC_IDLE_NS_1 / `HRPC_CLK_NS,
    parameter [31:0] IDLE_CYC_2 = `HRPC_IDLE_NS_2 / `HRPC_CLK_NS,
    parameter [31:0] IDLE_CYC_3 = `HRPC_IDLE_NS_3 / `HRPC_CLK_NS,
    parameter [31:0] RECON_CYC_LONG = `HRPC_RECON_NS_LONG / `HRPC_CLK_NS,
    parameter [31:0] RECON_CYC_SHORT = `HRPC_RECON_NS_SHORT / `HRPC_CLK_NS
) (
    // Clock, reset and clock enable.
    input wire i_clk_sys,
    input wire i_reset_n,
    input wire i_clk_en,
    // Avalon-MM slave.
    input wire [4:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    output reg [1:0] o_avs_response,
    // Buffer RAM data path.
    input wire i_data_access,
    output wire [ADDR_W-1:0] o_ram_addr,
    output wire o_access_direction,
    // Indirect register file at location 07.
    input wire [7:0] i_indirect_rdata,
    output wire [2:0] o_indirect_sel,
    output reg o_indirect_wr,
    output reg [7:0] o_indirect_wdata,
    // Protocol engine controls.
    output wire o_soft_reset,
    output wire o_queue_chain_on,
    output wire o_backplane,
    output wire [1:0] o_timeout_scale,
    output reg [31:0] o_resp_cycles,
    output reg [31:0] o_idle_cycles,
    output reg [31:0] o_recon_cycles,
    // Line outputs, active low, gated by transmit enable.
    input wire i_pulse_a_req,
    input wire i_pulse_b_req,
    input wire i_driver_req,
    output reg o_line_pulse_a_n,
    output reg o_line_pulse_b_n,
    output reg o_line_driver_on_n
);

    reg [7:0] ptr_upper_reg;
    reg [7:0] ptr_lower_reg;
    reg [4:0] config_hi_reg;
    reg sel_top_reg;
    reg [1:0] sel_low_reg;
    reg ack_reg;
    reg [7:0] rd_byte;
    reg hit;
    wire [ADDR_W-1:0] addr_step;
    wire [2:0] widx;
    wire wr_go;
    wire rd_go;
    wire lane0;
    wire ptr_wr;
    reg ptr_config_bp;

    // Each request is answered one cycle after it appears.
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
    assign widx = i_avs_address[4:2];
    assign wr_go = i_clk_en & i_avs_write & ack_reg;
    assign rd_go = i_clk_en & i_avs_read & ack_reg;
    assign lane0 = i_avs_byteenable[0];
    // Only a write to a pointer byte may hold off a step; other writes must not swallow it.
    assign ptr_wr = wr_go & lane0 & ((widx == `HRPC_IDX_PTR_UPPER) | (widx == `HRPC_IDX_PTR_LOWER));

    assign o_access_direction = ptr_upper_reg[`HRPC_BIT_DIR]; // [RL1]
    assign o_ram_addr = {ptr_upper_reg[2:0], ptr_lower_reg}; // [RL3]
    // Carry passes from the low byte into the upper bits; wraps at the top.
    assign addr_step = o_ram_addr + {{(ADDR_W-1){1'b0}}, 1'b1}; // [RL17]
    assign o_indirect_sel = {sel_top_reg, sel_low_reg}; // [RL5]
    assign o_soft_reset = config_hi_reg[`HRPC_BIT_SWRST-3]; // [RL8]
    assign o_queue_chain_on = config_hi_reg[`HRPC_BIT_CHAIN-3]; // [RL10]
    assign o_timeout_scale = config_hi_reg[1:0];
    assign o_backplane = ptr_config_bp;

    // Acknowledge toggles so back-to-back requests each wait one cycle.
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ack_reg <= 1'b0;
        end else if (i_clk_en) begin
            ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
        end
    end

    // Register writes and pointer stepping. Software reset is not applied here on purpose. [RL9]
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ptr_upper_reg <= `HRPC_BYTE_RESET; // [RL18]
            ptr_lower_reg <= `HRPC_BYTE_RESET;
            config_hi_reg <= 5'h00; // [RL18]
            ptr_config_bp <= 1'b0;
            sel_top_reg <= 1'b0;
            sel_low_reg <= 2'h0;
        end else begin
            // A bus write to a pointer byte wins over a step in the same cycle. [RL2]
            if (i_clk_en && i_data_access && ptr_upper_reg[`HRPC_BIT_STEP] && !ptr_wr) begin
                ptr_upper_reg[2:0] <= addr_step[ADDR_W-1:8];
                ptr_lower_reg <= addr_step[7:0];
            end
            if (wr_go && lane0) begin
                case (widx)
                    `HRPC_IDX_PTR_UPPER: begin
                        ptr_upper_reg <= {i_avs_writedata[7:6], 3'h0, i_avs_writedata[2:0]}; // [RL4]
                    end
                    `HRPC_IDX_PTR_LOWER: begin
                        ptr_lower_reg <= i_avs_writedata[7:0];
                    end
                    `HRPC_IDX_CONFIG: begin
                        config_hi_reg <= i_avs_writedata[7:3]; // [RL11] [RL13]
                        ptr_config_bp <= i_avs_writedata[`HRPC_BIT_BACKPLANE]; // [RL16]
                        sel_low_reg <= i_avs_writedata[1:0]; // [RL6]
                        sel_top_reg <= 1'b0; // [RL7]
                    end
                    `HRPC_IDX_SELECT: begin
                        sel_top_reg <= i_avs_writedata[2];
                        sel_low_reg <= i_avs_writedata[1:0]; // [RL6]
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read mux; reserved bits read zero, unmapped words answer with an error.
    always @* begin
        rd_byte = 8'h00;
        hit = 1'b1;
        case (widx)
            `HRPC_IDX_PTR_UPPER: rd_byte = {ptr_upper_reg[7:6], 3'h0, ptr_upper_reg[2:0]}; // [RL4]
            `HRPC_IDX_PTR_LOWER: rd_byte = ptr_lower_reg;
            `HRPC_IDX_CONFIG: rd_byte = {config_hi_reg, ptr_config_bp, sel_low_reg};
            `HRPC_IDX_SELECT: rd_byte = {5'h00, sel_top_reg, sel_low_reg}; // [RL4]
            `HRPC_IDX_INDIRECT: rd_byte = i_indirect_rdata;
            default: hit = 1'b0;
        endcase
    end

    // Read data and response register, indirect write strobe.
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_avs_readdata <= 32'h0000_0000;
            o_avs_response <= 2'h0;
            o_indirect_wr <= 1'b0;
            o_indirect_wdata <= 8'h00;
        end else if (i_clk_en) begin
            o_indirect_wr <= 1'b0;
            if (i_avs_read & ~ack_reg) begin
                o_avs_readdata <= {24'h00_0000, rd_byte};
                o_avs_response <= hit ? 2'h0 : 2'h2;
            end else if (i_avs_write & ~ack_reg) begin
                o_avs_response <= hit ? 2'h0 : 2'h2;
            end
            if (wr_go && lane0 && widx == `HRPC_IDX_INDIRECT) begin
                o_indirect_wr <= 1'b1; // [RL5]
                o_indirect_wdata <= i_avs_writedata[7:0];
            end
        end
    end

    // Timeout counts from the scale bits; same settings on all nodes assumed. [RL15]
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_resp_cycles <= RESP_CYC_0;
            o_idle_cycles <= IDLE_CYC_0;
            o_recon_cycles <= RECON_CYC_LONG;
        end else if (i_clk_en) begin
            case (o_timeout_scale)
                2'h0: begin
                    o_resp_cycles <= RESP_CYC_0; // [RL13]
                    o_idle_cycles <= IDLE_CYC_0;
                end
                2'h1: begin
                    o_resp_cycles <= RESP_CYC_1;
                    o_idle_cycles <= IDLE_CYC_1;
                end
                2'h2: begin
                    o_resp_cycles <= RESP_CYC_2;
                    o_idle_cycles <= IDLE_CYC_2;
                end
                default: begin
                    o_resp_cycles <= RESP_CYC_3;
                    o_idle_cycles <= IDLE_CYC_3;
                end
            endcase
            o_recon_cycles <= (o_timeout_scale == 2'h3) ? RECON_CYC_SHORT : RECON_CYC_LONG; // [RL14]
        end
    end

    // Line outputs stay inactive (high) while transmit enable is low. [RL11] [RL12]
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_line_pulse_a_n <= 1'b1;
            o_line_pulse_b_n <= 1'b1;
            o_line_driver_on_n <= 1'b1;
        end else if (i_clk_en) begin
            o_line_pulse_a_n <= ~(i_pulse_a_req & config_hi_reg[`HRPC_BIT_TXON-3]); // [RL11]
            o_line_pulse_b_n <= ~(i_pulse_b_req & config_hi_reg[`HRPC_BIT_TXON-3]);
            o_line_driver_on_n <= ~(i_driver_req & config_hi_reg[`HRPC_BIT_TXON-3]);
        end
    end

endmodule // hrpc_reg_bank
`default_nettype wire

/* test/hrpc_monitor.sv */
/* Checker for the register bank ports.
   Assumes one clock, i_clk_en held high and byte addresses as in the bank. */
`timescale 1ns/1ps
`default_nettype none
module hrpc_monitor (
    // Clock, reset and bus.
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic o_avs_waitrequest,
    // Pointer, select and controls.
    input wire logic i_data_access,
    input wire logic [10:0] o_ram_addr,
    input wire logic o_access_direction,
    input wire logic [2:0] o_indirect_sel,
    input wire logic o_soft_reset,
    input wire logic o_queue_chain_on,
    input wire logic o_backplane,
    input wire logic [1:0] o_timeout_scale,
    // Line side.
    input wire logic i_pulse_a_req,
    input wire logic o_line_pulse_a_n,
    input wire logic o_line_pulse_b_n,
    input wire logic o_line_driver_on_n
);
    wire [2:0] idx = i_avs_address[4:2];
    wire [7:0] wd = i_avs_writedata[7:0];
    wire wa = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    wire wp = wa && (idx == 3'h2 || idx == 3'h3); // Only pointer writes hold off a step.
    reg [7:0] cfg_reg;
    reg [1:0] ptr_reg;
    // Shadow of the bus writes; it lands on the same edge as the bank's own copy.
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cfg_reg <= 8'h00;
            ptr_reg <= 2'h0;
        end else if (wa && idx == 3'h6) begin
            cfg_reg <= wd;
        end else if (wa && idx == 3'h2) begin
            ptr_reg <= wd[7:6];
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    AST_DIR: assert property (o_access_direction == ptr_reg[1]) else $error("direction wrong");
    AST_STEP: assert property (i_data_access && ptr_reg[0] && !wp |=> o_ram_addr == $past(o_ram_addr) + 11'h001)
        else $error("pointer did not step");
    AST_HOLD: assert property (!i_data_access && !wp |=> $stable(o_ram_addr)) else $error("pointer moved");
    AST_LOW: assert property (wa && idx == 3'h3 |=> o_ram_addr[7:0] == $past(wd)) else $error("low address");
    AST_UP: assert property (wa && idx == 3'h2 |=> o_ram_addr[10:8] == $past(wd[2:0])) else $error("upper address");
    AST_SEL: assert property (wa && idx == 3'h4 |=> o_indirect_sel == $past(wd[2:0])) else $error("select");
    AST_CSEL: assert property (wa && idx == 3'h6 |=> o_indirect_sel == {1'b0, $past(wd[1:0])})
        else $error("select via config");
    AST_SWRST: assert property (o_soft_reset == cfg_reg[7]) else $error("soft reset level");
    AST_CHAIN: assert property (o_queue_chain_on == cfg_reg[6]) else $error("chaining level");
    AST_SCALE: assert property ({o_timeout_scale, o_backplane} == cfg_reg[4:2]) else $error("scale");
    AST_GATE: assert property (!cfg_reg[5] |=> o_line_pulse_a_n && o_line_pulse_b_n && o_line_driver_on_n)
        else $error("line output not gated");
    AST_PASS: assert property ($past(cfg_reg[5]) |-> o_line_pulse_a_n == !$past(i_pulse_a_req))
        else $error("line output not passed");
    // Main scenarios.
    cover property (wa && idx == 3'h6);
    cover property (i_data_access && ptr_reg[0]);
    cover property (cfg_reg[5] && !o_line_pulse_a_n);
endmodule // hrpc_monitor
bind hrpc_reg_bank hrpc_monitor mon_u (.*);
`default_nettype wire

/* test/hrpc_indirect_model.sv */
/* Model of the indirect register file behind location 07.
   Assumes the bank's select and one-cycle write pulse. */
`timescale 1ns/1ps
`default_nettype none
module hrpc_indirect_model (
    // Bank side.
    input wire logic i_clk_sys,
    input wire logic [2:0] i_sel,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [8];
    // Each entry starts with its own code so a wrong select shows.
    initial for (int k = 0; k < 8; k++) mem[k] = 8'hA0 | k[7:0];
    // Written on the pulse, read back by select.
    always @(posedge i_clk_sys) if (i_wr) mem[i_sel] <= i_wdata;
    assign o_rdata = mem[i_sel];
endmodule // hrpc_indirect_model
`default_nettype wire

/* test/tb.sv */
/* Bench for the register bank: bus tasks, scenarios and verdict.
   Assumes the bank, its checker and the indirect register model. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    reg clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, acc = 1'b0, pa = 1'b0, pb = 1'b0, pd = 1'b0;
    reg [4:0] adr = 5'h00;
    reg [31:0] wd = 32'h0000_0000, q;
    reg [1:0] r;
    wire [31:0] rdat, rc, ic, cc;
    wire [10:0] ra;
    wire [7:0] ird, iwd;
    wire [2:0] sel;
    wire [1:0] rsp, ts;
    wire wt, dir, iwr, srst, chn, bkp, la, lb, ld;
    int fail_count = 0, n_compared = 0;
    logic [31:0] resp [4] = '{32'h0024_6C38, 32'h0012_361C, 32'h0009_1B0E, 32'h0002_4702};
    logic [31:0] idle [4] = '{32'h0028_0A00, 32'h0014_0500, 32'h000A_0280, 32'h0002_80A0};
    // Clock at 250 MHz.
    always #2 clk = ~clk;
    hrpc_reg_bank dut_u (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_avs_response(rsp), .i_data_access(acc),
        .o_ram_addr(ra), .o_access_direction(dir), .i_indirect_rdata(ird), .o_indirect_sel(sel),
        .o_indirect_wr(iwr), .o_indirect_wdata(iwd), .o_soft_reset(srst), .o_queue_chain_on(chn),
        .o_backplane(bkp), .o_timeout_scale(ts), .o_resp_cycles(rc), .o_idle_cycles(ic),
        .o_recon_cycles(cc), .i_pulse_a_req(pa), .i_pulse_b_req(pb), .i_driver_req(pd),
        .o_line_pulse_a_n(la), .o_line_pulse_b_n(lb), .o_line_driver_on_n(ld));
    hrpc_indirect_model ind_u (.i_clk_sys(clk), .i_sel(sel), .i_wr(iwr), .i_wdata(iwd), .o_rdata(ird));
    task automatic chk(input [31:0] got, input [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer; held until waitrequest is seen low at an edge.
    task automatic bus(input bit w, input [2:0] i, input [7:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= {i, 2'h0};
        wd <= {24'h00_0000, d};
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        r = rsp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Registered outputs and timeout counts need two edges to land.
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask
    task automatic pulse;
        @(posedge clk);
        acc <= 1'b1;
        @(posedge clk);
        acc <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_reset;
        settle;
        chk({ra, dir, sel, la, lb, ld, srst}, 19'h0000E);
        chk(rc, resp[0]);
        bus(0, 3'h0, 8'h00);
        chk(r, 2'h2);
    endtask
    task automatic t_ptr;
        bus(1, 3'h2, 8'hC7);
        bus(1, 3'h3, 8'hFE);
        settle;
        chk({dir, ra}, 12'hFFE);
        pulse;
        chk(ra, 11'h7FF);
        pulse;
        chk(ra, 11'h000);
        pulse;
        chk(ra, 11'h001);
        bus(0, 3'h2, 8'h00);
        chk(q & 32'h0000_00C7, 32'h0000_00C0);
        bus(1, 3'h2, 8'h05);
        pulse;
        chk({dir, ra}, 12'h501);
    endtask
    task automatic t_sel;
        for (int k = 0; k < 5; k++) begin
            bus(1, 3'h4, k[7:0]);
            bus(0, 3'h7, 8'h00);
            chk({sel, q[7:0]}, {k[2:0], 8'hA0 | k[7:0]});
        end
        bus(1, 3'h6, 8'h07);
        bus(0, 3'h4, 8'h00);
        chk({sel, q[2:0]}, 6'h1B);
        bus(1, 3'h7, 8'h5A);
        bus(0, 3'h7, 8'h00);
        chk(q[7:0], 8'h5A);
    endtask
    task automatic t_cfg;
        for (int s = 0; s < 4; s++) begin
            bus(1, 3'h6, {3'h6, s[1:0], 3'h4});
            settle;
            chk({srst, chn, bkp, ts}, {3'h7, s[1:0]});
            chk({rc, ic}, {resp[s], idle[s]});
            chk(cc, s == 3 ? 32'h0019_A280 : 32'h0033_4500);
            bus(0, 3'h6, 8'h00);
            chk(q, {24'h00_0000, 3'h6, s[1:0], 3'h4});
        end
        bus(1, 3'h6, 8'h04);
        settle;
        chk({srst, chn}, 2'h0);
    endtask
    task automatic t_tx;
        @(posedge clk);
        pa <= 1'b1;
        pb <= 1'b1;
        pd <= 1'b1;
        settle;
        chk({la, lb, ld}, 3'h7);
        bus(1, 3'h6, 8'h24);
        settle;
        chk({la, lb, ld}, 3'h0);
        @(posedge clk);
        pb <= 1'b0;
        settle;
        chk({la, lb, ld}, 3'h2);
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_ptr;
        t_sel;
        t_cfg;
        t_tx;
        conclude;
    end
    // The scenarios need well under a thousand cycles; this cuts a hang.
    initial begin
        #40000;
        fail_count++;
        conclude;
    end
endmodule // tb
`default_nettype wire
